// *** logic/sms_spi.v ***
// How it works
// - As master the block drives the serial clock at the configured rate and mode.
// - Until control/status is written, the master bit in a control write is ignored.
// - In master mode a low select clears master and enable.
// - As master, every accepted data write made while no transfer is busy starts one transfer.
// - As master the byte leaves on the master-out pin, MSB first.
// - Completion sets the done flag; irq when enabled and cpu mask clear.
// - Master: done clears after status access while set, then a data read.
// - While done is set, data writes are ignored until status is read.
// - As slave the serial clock is an input from the far master.
// - As slave the byte leaves on the master-in pin, MSB first.
// - As slave shifting begins only on clock edges from the master.
// - Slave: done clears after status access while set, then data read or write.
`timescale 1ns/1ps
`default_nettype none
`include "sms_defs.vh"

module sms_spi (
   // Clock and reset
   input  wire       ref_clk,
   input  wire       rst_n,
   // Register access strobes
   input  wire       ctrl_wr,
   input  wire       csr_wr,
   input  wire       csr_rd,
   input  wire       data_wr,
   input  wire       data_rd,
   input  wire [7:0] wr_data,
   input  wire       cpu_irq_mask,
   // Register read-back
   output reg  [7:0] ctrl_q,
   output reg  [7:0] csr_q,
   output reg  [7:0] rx_data,
   output reg        rx_valid,
   output reg        irq_req,
   // Link pins
   input  wire       sck_in,
   output reg        sck_out,
   output reg        sck_oe,
   input  wire       mosi_in,
   output reg        mosi_out,
   output reg        mosi_oe,
   input  wire       miso_in,
   output reg        miso_out,
   output reg        miso_oe,
   input  wire       ss_n_in
);

   reg  [3:0]  sync_m_reg;
   reg  [3:0]  sync_s_reg;
   reg         sck_d_reg;
   reg         csr_written_reg;
   reg         csr_seen_reg;
   reg         clr_armed_reg;
   reg         busy_reg;
   reg  [4:0]  edge_cnt_reg;
   reg  [10:0] div_cnt_reg;
   reg         sck_tgl_reg;
   reg  [7:0]  shift_reg;
   reg  [7:0]  rx_shift_reg;
   reg  [7:0]  skid_data_reg;
   reg         skid_valid_reg;

   reg  [7:0]  ctrl_next;
   reg  [7:0]  csr_next;
   reg         csr_written_next;
   reg         csr_seen_next;
   reg         clr_armed_next;
   reg         busy_next;
   reg  [4:0]  edge_cnt_next;
   reg  [10:0] div_cnt_next;
   reg         sck_tgl_next;
   reg  [7:0]  shift_next;
   reg  [7:0]  rx_shift_next;
   reg  [7:0]  rx_data_next;
   reg         rx_valid_next;
   reg  [7:0]  skid_data_next;
   reg         skid_valid_next;
   reg         edge_now;
   reg         sample_now;
   reg         done_now;
   reg         push;
   reg  [10:0] half_len;

   wire sck_s  = sync_s_reg[0];
   wire mosi_s = sync_s_reg[1];
   wire miso_s = sync_s_reg[2];
   wire ss_s   = sync_s_reg[3];

   wire master = ctrl_q[`SMS_CTRL_MASTER];
   wire enable = ctrl_q[`SMS_CTRL_ENABLE];
   wire phase  = ctrl_q[`SMS_CTRL_PHASE];
   wire pol    = ctrl_q[`SMS_CTRL_POL];
   wire done   = csr_q[`SMS_CSR_DONE];
   wire ss_eff = csr_q[`SMS_CSR_SEL_MANAGE] ? csr_q[`SMS_CSR_SEL_LEVEL] : ss_s;
   wire wr_ok  = data_wr & ~(done & ~csr_seen_reg);
   wire m_act  = master & enable;
   wire s_act  = ~master & enable & ~ss_s;

   // Two-flop synchronisers for sck, mosi, miso and select
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         sync_m_reg <= 4'hF;
         sync_s_reg <= 4'hF;
         sck_d_reg  <= 1'b1;
      end else begin
         sync_m_reg <= {ss_n_in, miso_in, mosi_in, sck_in};
         sync_s_reg <= sync_m_reg;
         sck_d_reg  <= sync_s_reg[0];
      end
   end

   always @* begin
      ctrl_next        = ctrl_q;
      csr_next         = csr_q;
      csr_written_next = csr_written_reg;
      csr_seen_next    = csr_seen_reg;
      clr_armed_next   = clr_armed_reg;
      busy_next        = busy_reg;
      edge_cnt_next    = edge_cnt_reg;
      div_cnt_next     = div_cnt_reg;
      sck_tgl_next     = sck_tgl_reg;
      shift_next       = shift_reg;
      rx_shift_next    = rx_shift_reg;
      rx_data_next     = rx_data;
      rx_valid_next    = rx_valid;
      skid_data_next   = skid_data_reg;
      skid_valid_next  = skid_valid_reg;
      edge_now         = 1'b0;
      sample_now       = 1'b0;
      done_now         = 1'b0;
      push             = 1'b0;
      half_len = `SMS_HALF_BASE << ctrl_q[`SMS_CTRL_RATE_MSB:`SMS_CTRL_RATE_LSB];

      // Configuration writes
      if (csr_wr) begin
         csr_next[`SMS_CSR_SEL_LEVEL]  = wr_data[`SMS_CSR_SEL_LEVEL];
         csr_next[`SMS_CSR_SEL_MANAGE] = wr_data[`SMS_CSR_SEL_MANAGE];
         csr_next[`SMS_CSR_MODE_FAULT] = 1'b0;
         csr_written_next = 1'b1;
      end
      if (ctrl_wr) begin
         ctrl_next = wr_data;
         if (!csr_written_reg)
            ctrl_next[`SMS_CTRL_MASTER] = ctrl_q[`SMS_CTRL_MASTER];
      end
      if (m_act && !ss_eff) begin
         ctrl_next[`SMS_CTRL_MASTER]   = 1'b0;
         ctrl_next[`SMS_CTRL_ENABLE]   = 1'b0;
         csr_next[`SMS_CSR_MODE_FAULT] = 1'b1;
         busy_next = 1'b0;
      end

      // Software loads the shift register
      if (wr_ok && !busy_reg) begin
         shift_next    = wr_data;
         edge_cnt_next = 5'h00;
         div_cnt_next  = half_len;
         sck_tgl_next  = 1'b0;
         if (m_act)
            busy_next = 1'b1;
      end

      // Edge source: own divider as master, sampled pin as slave
      if (m_act && busy_reg) begin
         if (div_cnt_reg == 11'h000) begin
            edge_now     = 1'b1;
            div_cnt_next = half_len;
            sck_tgl_next = ~sck_tgl_reg;
         end else begin
            div_cnt_next = div_cnt_reg - 11'h001;
         end
      end else if (s_act && sck_s != sck_d_reg) begin
         edge_now  = 1'b1;
         busy_next = 1'b1;
      end
      if (!master && ss_s) begin
         busy_next     = 1'b0;
         edge_cnt_next = 5'h00;
      end

      // Sample and shift on alternating edges
      if (edge_now) begin
         sample_now = (edge_cnt_reg[0] == phase);
         if (sample_now)
            rx_shift_next = {rx_shift_reg[6:0], master ? miso_s : mosi_s};
         else if (!(phase && edge_cnt_reg == 5'h00))
            shift_next = {shift_reg[6:0], 1'b0};
         if (edge_cnt_reg == `SMS_LAST_EDGE) begin
            done_now      = 1'b1;
            busy_next     = 1'b0;
            edge_cnt_next = 5'h00;
         end else begin
            edge_cnt_next = edge_cnt_reg + 5'h01;
         end
      end

      // Receive buffer: output stage plus skid entry
      if (data_rd && rx_valid) begin
         if (skid_valid_reg) begin
            rx_data_next    = skid_data_reg;
            skid_valid_next = 1'b0;
         end else begin
            rx_valid_next = 1'b0;
         end
      end

      // Flag clear sequence
      if ((csr_rd || csr_wr) && done)
         clr_armed_next = 1'b1;
      if (csr_rd && done)
         csr_seen_next = 1'b1;
      if (clr_armed_reg && (data_rd || (!master && data_wr))) begin
         csr_next[`SMS_CSR_DONE]    = 1'b0;
         csr_next[`SMS_CSR_OVERRUN] = 1'b0;
         clr_armed_next = 1'b0;
         csr_seen_next  = 1'b0;
      end

      // Completion; set wins over clear
      if (done_now) begin
         if (done || (rx_valid && skid_valid_reg)) begin
            csr_next[`SMS_CSR_OVERRUN] = 1'b1;
         end else begin
            push = 1'b1;
         end
         csr_next[`SMS_CSR_DONE] = 1'b1;
         clr_armed_next = 1'b0;
         csr_seen_next  = 1'b0;
      end
      if (push) begin
         if (!rx_valid_next) begin
            rx_data_next  = rx_shift_next;
            rx_valid_next = 1'b1;
         end else begin
            skid_data_next  = rx_shift_next;
            skid_valid_next = 1'b1;
         end
      end
   end

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_q          <= `SMS_CTRL_RESET;
         csr_q           <= `SMS_CSR_RESET;
         csr_written_reg <= 1'b0;
         csr_seen_reg    <= 1'b0;
         clr_armed_reg   <= 1'b0;
         busy_reg        <= 1'b0;
         edge_cnt_reg    <= 5'h00;
         div_cnt_reg     <= 11'h000;
         sck_tgl_reg     <= 1'b0;
         shift_reg       <= `SMS_DATA_RESET;
         rx_shift_reg    <= `SMS_DATA_RESET;
         rx_data         <= `SMS_DATA_RESET;
         rx_valid        <= 1'b0;
         skid_data_reg   <= `SMS_DATA_RESET;
         skid_valid_reg  <= 1'b0;
         irq_req         <= 1'b0;
         sck_out         <= 1'b0;
         sck_oe          <= 1'b0;
         mosi_out        <= 1'b0;
         mosi_oe         <= 1'b0;
         miso_out        <= 1'b0;
         miso_oe         <= 1'b0;
      end else begin
         ctrl_q          <= ctrl_next;
         csr_q           <= csr_next;
         csr_written_reg <= csr_written_next;
         csr_seen_reg    <= csr_seen_next;
         clr_armed_reg   <= clr_armed_next;
         busy_reg        <= busy_next;
         edge_cnt_reg    <= edge_cnt_next;
         div_cnt_reg     <= div_cnt_next;
         sck_tgl_reg     <= sck_tgl_next;
         shift_reg       <= shift_next;
         rx_shift_reg    <= rx_shift_next;
         rx_data         <= rx_data_next;
         rx_valid        <= rx_valid_next;
         skid_data_reg   <= skid_data_next;
         skid_valid_reg  <= skid_valid_next;
         irq_req         <= csr_next[`SMS_CSR_DONE] & ctrl_next[`SMS_CTRL_IRQ_EN]
                            & ~cpu_irq_mask;
         sck_out         <= ctrl_next[`SMS_CTRL_POL] ^ sck_tgl_next;
         sck_oe          <= ctrl_next[`SMS_CTRL_MASTER] & ctrl_next[`SMS_CTRL_ENABLE];
         mosi_out        <= shift_next[7];
         mosi_oe         <= ctrl_next[`SMS_CTRL_MASTER] & ctrl_next[`SMS_CTRL_ENABLE];
         miso_out        <= shift_next[7];
         miso_oe         <= ~ctrl_next[`SMS_CTRL_MASTER] & ctrl_next[`SMS_CTRL_ENABLE]
                            & ~ss_s;
      end
   end

endmodule

`default_nettype wire

// *** logic/sms_defs.vh ***
`ifndef SMS_DEFS_VH
`define SMS_DEFS_VH

// Control byte fields
`define SMS_CTRL_RATE_LSB    0
`define SMS_CTRL_RATE_MSB    2
`define SMS_CTRL_PHASE       3
`define SMS_CTRL_POL         4
`define SMS_CTRL_MASTER      5
`define SMS_CTRL_ENABLE      6
`define SMS_CTRL_IRQ_EN      7
`define SMS_CTRL_RESET       8'h00

// Control/status byte fields
`define SMS_CSR_SEL_LEVEL    0
`define SMS_CSR_SEL_MANAGE   1
`define SMS_CSR_MODE_FAULT   5
`define SMS_CSR_OVERRUN      6
`define SMS_CSR_DONE         7
`define SMS_CSR_RESET        8'h00

// Link timing
`define SMS_HALF_BASE        11'h004
`define SMS_LAST_EDGE        5'h0F
`define SMS_DATA_RESET       8'h00

`endif

// *** dv/sms_spi_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module sms_spi_assertions (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_n,
   // Strobes
   input wire logic       csr_rd,
   input wire logic       data_wr,
   input wire logic       data_rd,
   input wire logic [7:0] wr_data,
   input wire logic       cpu_irq_mask,
   // Outputs
   input wire logic [7:0] ctrl_q,
   input wire logic [7:0] csr_q,
   input wire logic [7:0] rx_data,
   input wire logic       irq_req,
   input wire logic       sck_out,
   input wire logic       sck_oe,
   input wire logic       mosi_out
);
   logic seen_reg;
   logic busy_reg;
   wire  act  = ctrl_q[5] && ctrl_q[6];
   wire  take = data_wr && act && !busy_reg && (!csr_q[7] || seen_reg);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Status read seen while done, and a transfer in flight
   always @(posedge ref_clk) begin
      seen_reg <= rst_n && csr_q[7] && (seen_reg || csr_rd);
      busy_reg <= rst_n && ctrl_q[6] && (take || busy_reg) && !$rose(csr_q[7]) && !$rose(csr_q[6]);
   end
   a_irq_follows_done: assert property (irq_req == (csr_q[7] && ctrl_q[7] && !$past(cpu_irq_mask)))
      else $error("irq level wrong");
   a_master_drives_clk: assert property (act ##1 act |-> sck_oe)
      else $error("master clock not driven");
   a_slave_clk_in: assert property (!ctrl_q[5] && !$past(ctrl_q[5]) |-> !sck_oe)
      else $error("slave drives clock");
   a_write_blocked: assert property (csr_q[7] && !seen_reg && data_wr && act && !busy_reg
      |=> $stable(sck_out)[*8])
      else $error("blocked write started");
   a_done_clear_seq: assert property ($fell(csr_q[7])
      |-> $past(data_rd) || ($past(data_wr) && !ctrl_q[5]))
      else $error("done cleared without data access");
   a_select_low_fault: assert property (act && csr_q[1] && !csr_q[0]
      |-> ##[1:4] (ctrl_q[6:5] == 2'b00 && csr_q[5]))
      else $error("select low kept master");
   a_overrun_keeps: assert property ($rose(csr_q[6]) |-> csr_q[7] && $stable(rx_data))
      else $error("overrun lost byte");
   a_msb_first: assert property (take
      |=> (mosi_out == $past(wr_data[7])) ##[1:600] (sck_out != ctrl_q[4]))
      else $error("write did not start msb");
endmodule
bind sms_spi sms_spi_assertions chk_u (.ref_clk, .rst_n, .csr_rd, .data_wr, .data_rd,
   .wr_data, .cpu_irq_mask, .ctrl_q, .csr_q, .rx_data, .irq_req, .sck_out, .sck_oe,
   .mosi_out);
`default_nettype wire

// *** dv/sms_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module sms_peer (
   // Link
   input  wire logic       sck,
   input  wire logic       mosi,
   output var  logic       miso,
   // Bench side
   input  wire logic       load,
   input  wire logic       clock_phase,
   input  wire logic [7:0] tx_byte,
   output var  logic [7:0] rx_byte
);
   logic [7:0] sh_reg;
   logic       skip_reg;
   initial begin
      miso = 1'b0;
      rx_byte = 8'h00;
      skip_reg = 1'b0;
   end
   // Load shows the first bit before the first clock edge
   always @(posedge load) begin
      sh_reg = tx_byte;
      miso = tx_byte[7];
      skip_reg = clock_phase;
   end
   // Samples on rising edges, shifts on falling; phase one keeps bit 7 past the first fall
   always @(posedge sck) rx_byte = {rx_byte[6:0], mosi};
   always @(negedge sck) begin
      if (skip_reg) begin
         skip_reg = 1'b0;
      end else begin
         sh_reg = {sh_reg[6:0], ~sh_reg[7]};
         miso = sh_reg[7];
      end
   end
endmodule
`default_nettype wire

// *** dv/test_sms_spi.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_sms_spi;
   localparam logic [4:0] op_ctrl = 5'h10;
   localparam logic [4:0] op_csr  = 5'h08;
   localparam logic [4:0] op_rd   = 5'h04;
   localparam logic [4:0] op_dwr  = 5'h02;
   localparam logic [4:0] op_drd  = 5'h01;
   logic        ref_clk = 1'b0;
   logic        rst_n, ctrl_wr, csr_wr, csr_rd, data_wr, data_rd, cpu_irq_mask;
   logic [7:0]  wr_data, ctrl_q, csr_q, rx_data, tx_byte, peer_rx, d, p, got;
   logic        rx_valid, irq_req, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   logic        sck_drv, mosi_drv, ss_n_in, load, peer_miso, done_d, peer_clock_phase;
   logic [15:0] seed = 16'h793A;
   logic [7:0]  exp_q[$];
   int          fail_count = 0;
   int          checked = 0;
   wire         sck_w  = sck_oe ? sck_out : sck_drv;
   wire         mosi_w = mosi_oe ? mosi_out : mosi_drv;
   wire         miso_w = miso_oe ? miso_out : peer_miso;
   always #2 ref_clk = ~ref_clk;
   sms_spi dut_u (.ref_clk, .rst_n, .ctrl_wr, .csr_wr, .csr_rd, .data_wr, .data_rd, .wr_data,
      .cpu_irq_mask, .ctrl_q, .csr_q, .rx_data, .rx_valid, .irq_req, .sck_in(sck_w), .sck_out,
      .sck_oe, .mosi_in(mosi_w), .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe,
      .ss_n_in);
   sms_peer peer_u (.sck(sck_w), .mosi(mosi_w), .miso(peer_miso), .load, .clock_phase(peer_clock_phase),
      .tx_byte, .rx_byte(peer_rx));
   function logic [7:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction
   task give_verdict();
      $display("checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task check8(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: got %h, want %h", $time, g, e);
      end
   endtask
   task reg_op(input logic [4:0] op, input logic [7:0] v);
      @(posedge ref_clk);
      {ctrl_wr, csr_wr, csr_rd, data_wr, data_rd} <= op;
      wr_data <= v;
      @(posedge ref_clk);
      {ctrl_wr, csr_wr, csr_rd, data_wr, data_rd} <= 5'h00;
   endtask
   task wait_csr(input int b);
      int n;
      n = 0;
      while (csr_q[b] !== 1'b1 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 3000)
         check8(8'h00, 8'h01);
   endtask
   task mxfer(input logic [7:0] v, input logic [7:0] b);
      @(posedge ref_clk);
      tx_byte <= b;
      load <= 1'b1;
      reg_op(op_dwr, v);
      load <= 1'b0;
   endtask
   // Far master at 160 ns per bit, mode zero
   task sxfer(input logic [7:0] m);
      int i;
      @(posedge ref_clk);
      ss_n_in <= 1'b0;
      for (i = 7; i >= 0; i--) begin
         mosi_drv <= m[i];
         repeat (19) @(posedge ref_clk);
         @(negedge ref_clk);
         got[i] = miso_w;
         @(posedge ref_clk);
         sck_drv <= 1'b1;
         repeat (20) @(posedge ref_clk);
         sck_drv <= 1'b0;
      end
      repeat (20) @(posedge ref_clk);
      ss_n_in <= 1'b1;
   endtask
   // Received byte compared as the done flag rises
   always @(negedge ref_clk) begin
      done_d <= csr_q[7];
      if (csr_q[7] === 1'b1 && done_d !== 1'b1)
         check8(rx_data, exp_q.pop_front());
   end
   initial begin
      #100000;
      fail_count++;
      give_verdict();
   end
   initial begin
      {ctrl_wr, csr_wr, csr_rd, data_wr, data_rd} = 5'h00;
      {rst_n, cpu_irq_mask, sck_drv, mosi_drv, load, peer_clock_phase} = 6'h00;
      {ss_n_in, wr_data, tx_byte} = 17'h10000;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      reg_op(op_ctrl, 8'hE1);
      @(negedge ref_clk);
      check8(ctrl_q, 8'hC1);
      reg_op(op_csr, 8'h03);
      reg_op(op_ctrl, 8'hE1);
      d = rnd();
      p = rnd();
      exp_q.push_back(p);
      mxfer(d, p);
      wait_csr(7);
      check8(peer_rx, d);
      check8({4'h0, rx_valid, sck_oe, mosi_oe, miso_oe}, 8'h0E);
      check8({7'h00, irq_req}, 8'h01);
      @(posedge ref_clk);
      cpu_irq_mask <= 1'b1;
      repeat (2) @(negedge ref_clk);
      check8({7'h00, irq_req}, 8'h00);
      reg_op(op_dwr, ~d);
      repeat (60) @(negedge ref_clk);
      check8(peer_rx, d);
      reg_op(op_rd, 8'h00);
      mxfer(~d, rnd());
      wait_csr(6);
      check8(rx_data, p);
      check8(peer_rx, ~d);
      reg_op(op_rd, 8'h00);
      reg_op(op_drd, 8'h00);
      @(negedge ref_clk);
      check8(csr_q & 8'hC0, 8'h00);
      check8({7'h00, rx_valid}, 8'h00);
      // Polarity one, phase one, fastest rate; done cleared during the next byte
      reg_op(op_ctrl, 8'h78);
      peer_clock_phase <= 1'b1;
      d = rnd();
      p = rnd();
      exp_q.push_back(p);
      mxfer(d, p);
      wait_csr(7);
      check8({7'h00, sck_out}, 8'h01);
      check8(peer_rx, d);
      reg_op(op_rd, 8'h00);
      p = rnd();
      exp_q.push_back(p);
      mxfer(~d, p);
      reg_op(op_drd, 8'h00);
      @(negedge ref_clk);
      wait_csr(7);
      check8(csr_q & 8'hC0, 8'h80);
      check8(peer_rx, ~d);
      reg_op(op_rd, 8'h00);
      reg_op(op_drd, 8'h00);
      reg_op(op_csr, 8'h02);
      repeat (4) @(negedge ref_clk);
      check8({ctrl_q[6:5], csr_q[5]}, 8'h01);
      reg_op(op_csr, 8'h00);
      reg_op(op_ctrl, 8'h40);
      d = rnd();
      p = rnd();
      exp_q.push_back(p);
      reg_op(op_dwr, d);
      sxfer(p);
      wait_csr(7);
      check8(got, d);
      reg_op(op_rd, 8'h00);
      reg_op(op_dwr, 8'h00);
      @(negedge ref_clk);
      check8(csr_q & 8'h80, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
